// *** twe_pkg.sv ***
// ------------------------------------------------------------
// Shared constants of the two-wire memory link
// ------------------------------------------------------------
package twe_pkg;
    // Byte framing: bit counter value at the ninth clock and after it
    localparam int TWE_BYTE_BITS = 8;
    localparam logic [3:0] TWE_ACK_POS = 4'h8;
    localparam logic [3:0] TWE_ACK_END = 4'h9;
    // Array geometry: 8 pages of 256 bytes, 16-byte write groups
    localparam int TWE_ADDR_W = 11;
    localparam int TWE_PAGE_W = 3;
    localparam int TWE_GRP_W = 4;
    localparam int TWE_GRP_BYTES = 16;
    localparam int TWE_MEM_WORDS = 2048;
    // Device-type code in the top four address bits; value is arbitrary
    localparam logic [3:0] TWE_DEV_TYPE = 4'h6;
    // Write-cycle time, longest, counted on the link-side sample clock
    localparam int TWE_LINK_CLK_NS = 80;
    localparam int TWE_TWR_MS = 10;
    localparam int TWE_TWR_CYCLES = TWE_TWR_MS * 1_000_000 / TWE_LINK_CLK_NS;
    localparam int TWE_WCNT_W = $clog2(TWE_TWR_CYCLES + 1);
    // Master serial clock: four quarters per bit at 100 kHz
    localparam int TWE_CORE_CLK_NS = 25;
    localparam int TWE_SCL_KHZ = 100;
    localparam int TWE_QUARTER_CYCLES =
        1_000_000 / TWE_SCL_KHZ / 4 / TWE_CORE_CLK_NS;
    localparam int TWE_DIV_W = $clog2(TWE_QUARTER_CYCLES + 1);
endpackage : twe_pkg

// *** twe_bus_if.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-wire bus between master and memory
// ------------------------------------------------------------
interface twe_bus_if;
    logic scl;
    logic host_sda_val;
    logic host_sda_en;
    logic dev_sda_val;
    logic dev_sda_en;
    logic sda;
    // Pulled-up wired-AND line: low while any enabled driver sends zero
    assign sda = ~((host_sda_en & ~host_sda_val) |
                   (dev_sda_en & ~dev_sda_val));
    modport host (output scl, output host_sda_val, output host_sda_en,
                  input sda);
    modport dev (input scl, output dev_sda_val, output dev_sda_en,
                 input sda);
endinterface : twe_bus_if

// *** twe_dev_end.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Memory end: slave protocol engine, array and write cycle
// ------------------------------------------------------------
// Behaviour
// RULE_01 - Master alone clocks; memory never drives clock
// RULE_02 - Data changes only while clock is low
// RULE_03 - Falling data, clock high, is start
// RULE_04 - Rising data, clock high, stops; standby
// RULE_05 - Receiver pulls data low on ninth clock
// RULE_06 - Ack matching address and every written byte
// RULE_07 - Read: send byte, continue only if acked
// RULE_08 - Top four address bits are device type
// RULE_09 - Next three bits are page, address MSBs
// RULE_10 - Last address bit: one read, zero write
// RULE_11 - Word address, data, stop starts write cycle
// RULE_12 - Ignore everything during internal write cycle
// RULE_13 - Page write takes up to sixteen bytes
// RULE_14 - Only low four address bits wrap
// RULE_15 - No ack to polling until write done
// RULE_16 - Address counter is last address plus one
// RULE_17 - Random read: dummy write, repeated start, read
// RULE_18 - Master nacks last byte, then stops
// RULE_19 - Reads increment all eleven bits, wrap
// RULE_20 - Write cycle ends within ten milliseconds
// RULE_21 - Start aborts transfer, drops partial write
module twe_dev_end #(
    parameter logic [3:0] DEV_TYPE = twe_pkg::TWE_DEV_TYPE,
    parameter int WR_CYCLES = twe_pkg::TWE_TWR_CYCLES
) (
    // Link sample clock and its reset
    input wire logic link_clk,
    input wire logic rst,
    // Two-wire bus
    twe_bus_if.dev bus,
    // Status toward the user
    output logic standby,
    output logic write_busy
);
    import twe_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DS_IDLE, DS_DEV, DS_WORD, DS_WDATA, DS_READ, DS_WAIT, DS_BUSY
    } twe_dst_t;

    typedef struct packed {
        twe_dst_t st;
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        logic [3:0] cnt;
        logic [TWE_BYTE_BITS-1:0] sh;
        logic [TWE_BYTE_BITS-1:0] tx;
        logic [TWE_ADDR_W-1:0] addr;
        logic [TWE_PAGE_W-1:0] page;
        logic rw;
        logic drv;
        logic [TWE_GRP_BYTES-1:0] mask;
        logic [TWE_WCNT_W-1:0] wcnt;
    } twe_dev_state_t;

    twe_dev_state_t s_reg;
    twe_dev_state_t s_next;

    logic [TWE_BYTE_BITS-1:0] mem [TWE_MEM_WORDS];
    logic [TWE_BYTE_BITS-1:0] pbuf [TWE_GRP_BYTES];
    logic [TWE_BYTE_BITS-1:0] rd_byte;
    logic start_ev;
    logic stop_ev;
    logic rise_ev;
    logic fall_ev;
    logic busy;
    logic buf_wr;
    logic mem_wr;
    logic [TWE_GRP_W-1:0] wslot;

    // ------------------------------------------------------------
    // Bus events from synchronised, delayed copies of the lines
    // ------------------------------------------------------------
    // Edges compare second sync stage with its delayed copy only
    assign start_ev = s_reg.scl_p & s_reg.scl_s & s_reg.sda_p
                      & ~s_reg.sda_s; // RULE_03
    assign stop_ev = s_reg.scl_p & s_reg.scl_s & ~s_reg.sda_p
                     & s_reg.sda_s; // RULE_04
    assign rise_ev = s_reg.scl_s & ~s_reg.scl_p;
    assign fall_ev = ~s_reg.scl_s & s_reg.scl_p;
    assign busy = (s_reg.st == DS_BUSY);
    assign rd_byte = mem[s_reg.addr];
    assign wslot = s_reg.wcnt[TWE_GRP_W-1:0];

    // Byte lands in the group buffer at its ack clock, not in the array
    assign buf_wr = !busy && !start_ev && !stop_ev && fall_ev
                    && s_reg.cnt == TWE_ACK_POS && s_reg.st == DS_WDATA;
    // Commit one buffered byte per cycle at the start of the write cycle
    assign mem_wr = busy && s_reg.wcnt < TWE_WCNT_W'(TWE_GRP_BYTES)
                    && s_reg.mask[wslot];

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Only ever pulls the data line low; the clock is an input here
    assign bus.dev_sda_val = 1'b0; // RULE_01
    assign bus.dev_sda_en = s_reg.drv;
    assign standby = (s_reg.st == DS_IDLE); // RULE_04
    assign write_busy = busy;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.scl_m = bus.scl;
        s_next.scl_s = s_reg.scl_m;
        s_next.scl_p = s_reg.scl_s;
        s_next.sda_m = bus.sda;
        s_next.sda_s = s_reg.sda_m;
        s_next.sda_p = s_reg.sda_s;
        if (busy) begin // RULE_15
            // Deaf and silent until the timed write finishes
            s_next.drv = 1'b0; // RULE_12
            s_next.wcnt = s_reg.wcnt + 1'b1;
            if (s_reg.wcnt == TWE_WCNT_W'(WR_CYCLES - 1)) begin
                s_next.st = DS_IDLE; // RULE_20
                s_next.mask = '0;
            end
        end else if (start_ev) begin
            // Any start outside the write cycle restarts address reception; a half-written
            // group is dropped so it can never reach the array
            s_next.st = DS_DEV; // RULE_21
            s_next.cnt = '0;
            s_next.drv = 1'b0;
            s_next.mask = '0;
        end else if (stop_ev) begin
            s_next.drv = 1'b0;
            s_next.cnt = '0;
            s_next.wcnt = '0;
            if (s_reg.st == DS_WDATA && |s_reg.mask) begin
                s_next.st = DS_BUSY; // RULE_11
            end else begin
                s_next.st = DS_IDLE; // RULE_04
            end
        end else if (s_reg.st == DS_IDLE || s_reg.st == DS_WAIT) begin
            s_next.drv = 1'b0; // RULE_07
        end else if (rise_ev) begin
            // Data is sampled on the rising clock only
            if (s_reg.cnt < TWE_ACK_POS) begin
                s_next.sh = {s_reg.sh[TWE_BYTE_BITS-2:0],
                             s_reg.sda_s}; // RULE_02
            end else if (s_reg.st == DS_READ && s_reg.sda_s) begin
                s_next.st = DS_WAIT; // RULE_07
            end
            s_next.cnt = s_reg.cnt + 4'h1;
        end else if (fall_ev) begin
            // The line is only changed just after the clock falls
            if (s_reg.cnt == TWE_ACK_POS) begin
                unique case (s_reg.st)
                    DS_DEV: begin
                        if (s_reg.sh[7:4] == DEV_TYPE) begin // RULE_08
                            s_next.drv = 1'b1; // RULE_06
                            s_next.page = s_reg.sh[3:1]; // RULE_09
                            s_next.rw = s_reg.sh[0]; // RULE_10
                        end else begin
                            s_next.st = DS_IDLE;
                        end
                    end
                    DS_WORD: begin
                        s_next.drv = 1'b1; // RULE_05
                        s_next.addr = {s_reg.page, s_reg.sh}; // RULE_09
                    end
                    DS_WDATA: begin
                        s_next.drv = 1'b1; // RULE_06
                        s_next.mask[s_reg.addr[TWE_GRP_W-1:0]] =
                            1'b1; // RULE_13
                        s_next.addr[TWE_GRP_W-1:0] =
                            s_reg.addr[TWE_GRP_W-1:0] + 4'h1; // RULE_14
                    end
                    DS_READ: begin
                        s_next.drv = 1'b0; // RULE_05
                    end
                    default: begin
                        s_next.drv = 1'b0;
                    end
                endcase
            end else if (s_reg.cnt == TWE_ACK_END) begin
                s_next.cnt = '0;
                if (s_reg.st == DS_READ || (s_reg.st == DS_DEV && s_reg.rw))
                begin
                    // Fetch at the counter and step all eleven bits
                    s_next.st = DS_READ; // RULE_10
                    s_next.tx = rd_byte; // RULE_16
                    s_next.addr = s_reg.addr + 11'h001; // RULE_19
                    s_next.drv = ~rd_byte[TWE_BYTE_BITS-1];
                end else begin
                    s_next.drv = 1'b0;
                    if (s_reg.st == DS_DEV) begin
                        s_next.st = DS_WORD;
                    end else if (s_reg.st == DS_WORD) begin
                        s_next.st = DS_WDATA;
                    end
                end
            end else if (s_reg.st == DS_READ && s_reg.cnt != '0) begin
                // Shift out the next bit, most significant first
                s_next.tx = {s_reg.tx[TWE_BYTE_BITS-2:0], 1'b0};
                s_next.drv = ~s_reg.tx[TWE_BYTE_BITS-2]; // RULE_02
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        if (rst) begin
            s_reg <= '0;
            // Line copies wake at the idle level: no false edge after reset
            s_reg.scl_m <= 1'b1;
            s_reg.scl_s <= 1'b1;
            s_reg.scl_p <= 1'b1;
            s_reg.sda_m <= 1'b1;
            s_reg.sda_s <= 1'b1;
            s_reg.sda_p <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Group buffer and array; contents are not reset, like a real array
    always_ff @(posedge link_clk) begin
        if (buf_wr) begin
            pbuf[s_reg.addr[TWE_GRP_W-1:0]] <= s_reg.sh; // RULE_14
        end
        if (mem_wr) begin
            mem[{s_reg.addr[TWE_ADDR_W-1:TWE_GRP_W], wslot}] <=
                pbuf[wslot]; // RULE_11
        end
    end
endmodule : twe_dev_end

// *** twe_host_end.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Master end: byte-level command engine driving the bus clock
// ------------------------------------------------------------
module twe_host_end #(
    parameter int QUARTER = twe_pkg::TWE_QUARTER_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Two-wire bus
    twe_bus_if.host bus,
    // Byte command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_start,
    input wire logic cmd_stop,
    input wire logic cmd_read,
    input wire logic cmd_mack,
    input wire logic [twe_pkg::TWE_BYTE_BITS-1:0] cmd_data,
    // Byte result
    output logic rsp_valid,
    output logic [twe_pkg::TWE_BYTE_BITS-1:0] rsp_data,
    output logic rsp_ack
);
    import twe_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} twe_hst_t;

    typedef struct packed {
        twe_hst_t st;
        logic [1:0] q;
        logic [TWE_DIV_W-1:0] div;
        logic [3:0] bcnt;
        logic [TWE_BYTE_BITS-1:0] sh;
        logic stop;
        logic rd;
        logic mack;
        logic scl;
        logic sda_en;
        logic sda_m;
        logic sda_s;
        logic rsp_valid;
        logic [TWE_BYTE_BITS-1:0] rsp_data;
        logic rsp_ack;
    } twe_host_state_t;

    twe_host_state_t s_reg;
    twe_host_state_t s_next;
    logic tick;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tick = (s_reg.div == TWE_DIV_W'(QUARTER - 1));
    assign bus.scl = s_reg.scl; // RULE_01
    assign bus.host_sda_val = 1'b0;
    assign bus.host_sda_en = s_reg.sda_en;
    assign cmd_ready = (s_reg.st == HS_IDLE);
    assign rsp_valid = s_reg.rsp_valid;
    assign rsp_data = s_reg.rsp_data;
    assign rsp_ack = s_reg.rsp_ack;

    // ------------------------------------------------------------
    // Next-state logic: each bit is four quarters, low-low-high-high
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.sda_m = bus.sda;
        s_next.sda_s = s_reg.sda_m;
        s_next.rsp_valid = 1'b0;
        s_next.div = (s_reg.st == HS_IDLE || tick) ? '0 :
                     s_reg.div + 1'b1;
        if (s_reg.st != HS_IDLE && tick) begin
            s_next.q = s_reg.q + 2'h1;
        end
        unique case (s_reg.st)
            HS_IDLE: begin
                // Lines hold as left, so a repeated start keeps clock low
                if (cmd_valid) begin
                    s_next.st = cmd_start ? HS_START : HS_BIT; // RULE_17
                    s_next.q = '0;
                    s_next.bcnt = '0;
                    s_next.sh = cmd_data; // RULE_08
                    s_next.stop = cmd_stop;
                    s_next.rd = cmd_read;
                    s_next.mack = cmd_mack;
                end
            end
            HS_START: begin
                if (tick) begin
                    unique case (s_reg.q)
                        2'h0: s_next.sda_en = 1'b0;
                        2'h1: s_next.scl = 1'b1;
                        2'h2: s_next.sda_en = 1'b1; // RULE_03
                        2'h3: begin
                            s_next.scl = 1'b0;
                            s_next.st = HS_BIT;
                        end
                    endcase
                end
            end
            HS_BIT: begin
                if (tick) begin
                    unique case (s_reg.q)
                        2'h0: begin
                            // Drive only while the clock is low
                            if (s_reg.bcnt == TWE_ACK_POS) begin
                                s_next.sda_en = s_reg.rd
                                    & s_reg.mack; // RULE_18
                            end else begin
                                s_next.sda_en = ~s_reg.rd
                                    & ~s_reg.sh[TWE_BYTE_BITS-1]; // RULE_02
                            end
                        end
                        2'h1: s_next.scl = 1'b1;
                        2'h2: s_next.scl = 1'b1;
                        2'h3: begin
                            s_next.scl = 1'b0;
                            if (s_reg.bcnt == TWE_ACK_POS) begin
                                s_next.rsp_ack = ~s_reg.sda_s; // RULE_05
                                s_next.rsp_data = s_reg.sh;
                                if (s_reg.stop) begin
                                    s_next.st = HS_STOP;
                                end else begin
                                    s_next.st = HS_IDLE;
                                    s_next.rsp_valid = 1'b1;
                                end
                            end else begin
                                s_next.sh = {s_reg.sh[TWE_BYTE_BITS-2:0],
                                             s_reg.sda_s};
                                s_next.bcnt = s_reg.bcnt + 4'h1;
                            end
                        end
                    endcase
                end
            end
            HS_STOP: begin
                // Ends writes, polls and reads alike
                if (tick) begin
                    unique case (s_reg.q)
                        2'h0: s_next.sda_en = 1'b1;
                        2'h1: s_next.scl = 1'b1;
                        2'h2: s_next.sda_en = 1'b0; // RULE_04
                        2'h3: begin
                            s_next.st = HS_IDLE;
                            s_next.rsp_valid = 1'b1;
                        end
                    endcase
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register; the bus idles with the clock high
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.scl <= 1'b1;
            s_reg.sda_m <= 1'b1;
            s_reg.sda_s <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : twe_host_end

// *** twe_link_asserts.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Protocol checks on the two-wire link
// ------------------------------------------------------------
module twe_link_asserts #(
    parameter int WR_CYCLES = twe_pkg::TWE_TWR_CYCLES
) (
    // Memory clock and reset
    input wire logic link_clk,
    input wire logic rst,
    // Bus lines
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_val,
    input wire logic host_sda_en,
    input wire logic dev_sda_val,
    input wire logic dev_sda_en,
    // Memory status
    input wire logic standby,
    input wire logic write_busy
);
    import twe_pkg::*;
    typedef struct packed {
        logic [TWE_WCNT_W:0] busy_cnt;
    } twe_chk_state_t;
    twe_chk_state_t s_reg;
    twe_chk_state_t s_next;
    // Length of the running write cycle, saturating so it cannot wrap
    always_comb begin
        s_next = s_reg;
        if (!write_busy) begin
            s_next.busy_cnt = '0;
        end else if (s_reg.busy_cnt != '1) begin
            s_next.busy_cnt = s_reg.busy_cnt + 1'b1;
        end
    end
    always_ff @(posedge link_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (rst);
    a_busy_line_free: assert property (write_busy |-> !dev_sda_en)
        else $error("memory pulled data during write cycle");
    a_busy_time_bound: assert property (
        int'(s_reg.busy_cnt) <= WR_CYCLES + 4)
        else $error("write cycle ran too long");
    a_busy_from_stop: assert property (
        $rose(write_busy) |-> scl && sda)
        else $error("write cycle began without a stop");
    a_change_clk_low: assert property (
        $changed(dev_sda_en) |-> !scl)
        else $error("memory changed data while clock high");
    a_dev_open_drain: assert property (dev_sda_val == 1'b0)
        else $error("memory drove data high");
    a_idle_released: assert property (standby |-> !dev_sda_en)
        else $error("memory pulled data while idle");
    a_stop_to_standby: assert property (
        scl && $rose(sda) && !write_busy
        |-> ##[1:8] (standby || write_busy))
        else $error("stop did not return memory to standby");
    a_start_wakes: assert property (scl && $fell(sda) && !write_busy
        |-> ##[1:8] !standby)
        else $error("start did not wake memory");
endmodule : twe_link_asserts

// *** two_wire_eeprom_slave_bench.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Master and memory ends joined on one bus
// ------------------------------------------------------------
module two_wire_eeprom_slave_bench;
    import twe_pkg::*;
    localparam int QTR = 20;
    localparam int WRC = 200;
    localparam int CEIL = 90000;
    typedef struct packed {
        logic st;
        logic sp;
        logic rd;
        logic mk;
        logic poll;
        logic [7:0] dat;
        logic ack;
    } twe_row_t;
    logic core_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_start = 1'b0;
    logic cmd_stop = 1'b0;
    logic cmd_read = 1'b0;
    logic cmd_mack = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready, rsp_valid, rsp_ack, standby, write_busy;
    logic [7:0] rsp_data;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int scl_rises = 0;
    // Rows: start, stop, read, master ack, poll, byte, expected ack
    twe_row_t rows [12] = '{
        '{1, 0, 0, 0, 0, 8'h6E, 1}, '{0, 0, 0, 0, 0, 8'hFF, 1},
        '{0, 1, 0, 0, 0, 8'hC3, 1}, '{1, 1, 0, 0, 0, 8'h6E, 0},
        '{1, 0, 0, 0, 1, 8'h60, 1}, '{0, 0, 0, 0, 0, 8'h00, 1},
        '{0, 1, 0, 0, 0, 8'h3C, 1}, '{1, 0, 0, 0, 1, 8'h6E, 1},
        '{0, 0, 0, 0, 0, 8'hFF, 1}, '{1, 0, 0, 0, 0, 8'h6F, 1},
        '{0, 0, 1, 1, 0, 8'hC3, 1}, '{0, 1, 1, 0, 0, 8'h3C, 0}};
    // ------------------------------------------------------------
    // Clocks, design and checker
    // ------------------------------------------------------------
    always #12.5 core_clk = ~core_clk;
    // Odd start offset keeps the link clock out of phase with the core
    initial begin
        #7;
        forever #40 link_clk = ~link_clk;
    end
    twe_bus_if i_twe_bus_if ();
    twe_host_end #(.QUARTER(QTR)) i_twe_host_end (.core_clk(core_clk),
        .rst(rst), .bus(i_twe_bus_if.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
        .cmd_read(cmd_read), .cmd_mack(cmd_mack), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    twe_dev_end #(.WR_CYCLES(WRC)) i_twe_dev_end (.link_clk(link_clk),
        .rst(rst), .bus(i_twe_bus_if.dev), .standby(standby),
        .write_busy(write_busy));
    twe_link_asserts #(.WR_CYCLES(WRC)) i_twe_link_asserts (
        .link_clk(link_clk), .rst(rst), .scl(i_twe_bus_if.scl),
        .sda(i_twe_bus_if.sda), .host_sda_val(i_twe_bus_if.host_sda_val),
        .host_sda_en(i_twe_bus_if.host_sda_en),
        .dev_sda_val(i_twe_bus_if.dev_sda_val),
        .dev_sda_en(i_twe_bus_if.dev_sda_en), .standby(standby),
        .write_busy(write_busy));
    always @(posedge i_twe_bus_if.scl) scl_rises++;
    // Hang guard: a stuck handshake ends the run as a failure
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == CEIL) begin
            mismatches++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One byte command; clock rises counted to check the ninth-clock frame
    task automatic cmd(input logic st, sp, rd, mk, input logic [7:0] dat);
        int exp_rises;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        exp_rises = 9 + int'(sp) + int'(st & ~i_twe_bus_if.scl);
        scl_rises = 0;
        {cmd_valid, cmd_start, cmd_stop} = {1'b1, st, sp};
        {cmd_read, cmd_mack} = {rd, mk};
        cmd_data = dat;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge core_clk);
        chk("clock rises", 8'(exp_rises), 8'(scl_rises));
    endtask : cmd
    task automatic poll(input logic [7:0] adr);
        int n;
        n = 0;
        do begin
            cmd(1, 0, 0, 0, adr);
            n++;
        end while (rsp_ack !== 1'b1 && n < 20);
        chk("poll ack", 8'h01, {7'h00, rsp_ack});
    endtask : poll
    // Dummy write of a word address, repeated start, then reads
    task automatic rd_at(input logic [7:0] dw, wd, input logic [7:0] e [$]);
        cmd(1, 0, 0, 0, dw);
        cmd(0, 0, 0, 0, wd);
        cmd(1, 0, 0, 0, dw | 8'h01);
        foreach (e[k]) begin
            cmd(0, k == e.size() - 1, 1, k != e.size() - 1, 8'hFF);
            chk("read data", e[k], rsp_data);
        end
    endtask : rd_at
    task automatic do_reset;
        rst = 1'b1;
        repeat (3) @(negedge link_clk);
        @(negedge core_clk);
        rst = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("standby", 8'h01, {7'h00, standby});
        chk("write busy", 8'h00, {7'h00, write_busy});
        chk("bus idle", 8'h03,
            {6'h00, i_twe_bus_if.scl, i_twe_bus_if.sda});
    endtask : do_reset
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        for (int i = 0; i < 12; i++) begin
            if (rows[i].poll) begin
                poll(rows[i].dat);
            end else begin
                cmd(rows[i].st, rows[i].sp, rows[i].rd,
                    rows[i].mk, rows[i].dat);
            end
            chk("row data", rows[i].dat, rsp_data);
            chk("row ack", {7'h00, rows[i].ack},
                {7'h00, rsp_ack});
        end
        // Seventeen bytes into one group: the last overwrites the first
        cmd(1, 0, 0, 0, 8'h64);
        cmd(0, 0, 0, 0, 8'h2E);
        for (int i = 0; i < 17; i++) begin
            cmd(0, i == 16, 0, 0, 8'h40 + 8'(i));
            chk("page ack", 8'h01, {7'h00, rsp_ack});
        end
        poll(8'h64);
        cmd(1, 0, 0, 0, 8'h65);
        cmd(0, 1, 1, 0, 8'hFF);
        chk("current read", 8'h41, rsp_data);
        rd_at(8'h64, 8'h2D, '{8'h4F, 8'h50, 8'h41});
        // A start mid-write drops the byte and launches no write cycle
        cmd(1, 0, 0, 0, 8'h64);
        cmd(0, 0, 0, 0, 8'h20);
        cmd(0, 0, 0, 0, 8'h99);
        cmd(1, 0, 0, 0, 8'h64);
        chk("abort ack", 8'h01, {7'h00, rsp_ack});
        chk("abort busy", 8'h00, {7'h00, write_busy});
        rd_at(8'h64, 8'h20, '{8'h42});
        // Foreign device type gets no answer
        cmd(1, 1, 0, 0, 8'hE4);
        chk("foreign ack", 8'h00, {7'h00, rsp_ack});
        repeat (40) @(negedge core_clk);
        chk("standby after stop", 8'h01, {7'h00, standby});
        do_reset();
        end_sim();
    end
endmodule : two_wire_eeprom_slave_bench
